// ### fcu_flash_ctl_unit.sv
// Flash control unit: AHB-Lite slave for flash array and its registers.
// Assumes a flash macro that acks each request with a one-cycle pulse.
`timescale 1ns/10ps
module fcu_flash_ctl_unit (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // AHB-Lite slave
  input  wire logic                          i_hsel,
  input  wire logic [31:0]                   i_haddr,
  input  wire logic [1:0]                    i_htrans,
  input  wire logic                          i_hwrite,
  input  wire logic [2:0]                    i_hsize,
  input  wire logic [31:0]                   i_hwdata,
  input  wire logic                          i_hready,
  output logic                               o_hreadyout,
  output logic                               o_hresp,
  output logic [31:0]                        o_hrdata,
  // Flash macro
  output fcu_pkg::fcu_flash_req_type         o_flash,
  input  wire logic                          i_fl_ack,
  input  wire logic [31:0]                   i_fl_rdata,
  // Option words from the macro
  input  wire logic [31:0]                   i_opt_read_guard_word,
  input  wire logic [7:0][31:0]              i_opt_write_guard_words,
  // Mode pins
  input  wire logic                          i_debug_mode,
  input  wire logic                          i_sram_boot,
  // Status
  output logic                               o_irq_hold,
  output logic                               o_read_guard_active
);
  import fcu_pkg::*;

  fcu_bus_type                st_q, st_d;
  fcu_key_type                key_q, key_d;
  fcu_flash_req_type          flash_q, flash_d;
  logic [18:0]                addr_q;
  logic                       write_q, word_q;
  logic [CTL_SEL_W-1:0]       ctrl_q;
  logic                       boot_step_q, boot_open_q, opt_step_q, opt_wr_q;
  logic                       busy_q, blank_q, guard_q, done_q;
  logic [31:0]                target_q, rdata_q, rdata_d, reg_view;
  logic                       hready_q, hresp_q;
  logic                       dbg_meta_q, dbg_q, sram_meta_q, sram_q;
  logic                       loaded_q, rdp_active_q;
  logic [31:0]                rg_eff;
  logic [WRP_WORDS*WRP_BITS-1:0] wrp_q, wrp_eff;

  //--------------------------------------------------------------
  // Option word checks
  //--------------------------------------------------------------
  function automatic logic [31:0] opt_eff(input logic [31:0] w);
    opt_eff = (w[31:16] == ~w[15:0]) ? w : OPT_DEFAULT;
  endfunction

  function automatic logic page_guarded(input logic [17:0] a,
                                        input logic [WRP_WORDS*WRP_BITS-1:0] write_guard_bits,
                                        input logic boot_open, input logic restricted);
    logic [7:0] page;
    page = a[PAGE_MSB:PAGE_LSB];
    page_guarded = (a >= MAIN_LIMIT) | !write_guard_bits[page[7:1]]
                   | ((page < BOOT_PAGES) & !boot_open)
                   | restricted;
  endfunction

  function automatic logic is_opt_page(input logic [17:0] a);
    is_opt_page = (a[17:PAGE_LSB] == NVR1_BASE[17:PAGE_LSB])
                | (a[17:PAGE_LSB] == NVR3_BASE[17:PAGE_LSB]);
  endfunction

  for (genvar gi = 0; gi < WRP_WORDS; gi++) begin : g_wrp
    wire [31:0] w_eff = opt_eff(i_opt_write_guard_words[gi]);
    assign wrp_eff[gi*WRP_BITS +: WRP_BITS] = w_eff[15:0];
  end

  assign rg_eff = opt_eff(i_opt_read_guard_word);

  //--------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------
  wire        accept     = i_hsel & i_htrans[1] & i_hready;
  wire        in_data    = (st_q == BUS_DATA);
  wire        is_reg     = addr_q[REG_SEL_BIT];
  wire [7:0]  ofs        = addr_q[7:0];
  wire [17:0] fl_addr    = {addr_q[17:2], 2'b00};
  wire        reg_known  = (addr_q[17:8] == 10'h000) & (ofs <= OFS_PROT) & (ofs[1:0] == 2'b00);
  wire        flash_hit  = (addr_q[17:0] <= FLASH_TOP);
  wire        bad_access = in_data & (is_reg ? !reg_known : !flash_hit);
  wire        reg_wr     = in_data & write_q & is_reg & word_q & reg_known;
  wire        fl_wr      = in_data & write_q & !is_reg & word_q & flash_hit;
  wire        fl_rd      = in_data & !write_q & !is_reg & flash_hit;
  wire        ctl_open   = (key_q == KEY_OPEN);
  wire        restricted = dbg_q | sram_q;

  wire        key_wr     = reg_wr & (ofs == OFS_UNLOCK);
  wire        boot_wr    = reg_wr & (ofs == OFS_BOOT_UNLOCK);
  wire        optk_wr    = reg_wr & (ofs == OFS_OPT_UNLOCK);
  wire        ctl_wr     = reg_wr & (ofs == OFS_CTRL);
  wire        stat_wr    = reg_wr & (ofs == OFS_STATUS);
  wire        tgt_wr     = reg_wr & (ofs == OFS_TARGET) & ctl_open;
  wire        is_first   = (i_hwdata == UNLOCK_WORD_FIRST);
  wire        is_second  = (i_hwdata == UNLOCK_WORD_SECOND);
  wire        key_bad    = key_wr & (((key_q == KEY_WAIT_FIRST) & !is_first)
                         | ((key_q == KEY_WAIT_SECOND) & !is_second)
                         | (key_q == KEY_DEAD));
  wire        bus_error  = bad_access | key_bad;

  // Control writes only land while unlocked
  wire        relock     = ctl_wr & ctl_open & i_hwdata[CTL_RELOCK];
  wire        ctl_take   = ctl_wr & ctl_open & !i_hwdata[CTL_RELOCK];
  wire        start      = ctl_take & i_hwdata[CTL_START];
  wire        go_mass    = start & i_hwdata[CTL_MASS_ER];
  wire        go_page    = start & !i_hwdata[CTL_MASS_ER] & i_hwdata[CTL_PAGE_ER];
  wire        go_opter   = start & !i_hwdata[CTL_MASS_ER] & !i_hwdata[CTL_PAGE_ER]
                         & i_hwdata[CTL_OPT_ER];
  wire        tgt_guard  = page_guarded(target_q[17:0], wrp_q, boot_open_q, restricted);
  wire        page_ok    = go_page & !tgt_guard;
  wire        opter_ok   = go_opter & opt_wr_q & is_opt_page(target_q[17:0]);
  wire        start_bad  = (go_page & tgt_guard) | (go_opter & !opter_ok);

  // Word programming through a flash-space write
  wire        sel_prog   = ctl_open & ctrl_q[CTL_PROG];
  wire        sel_oprog  = ctl_open & !ctrl_q[CTL_PROG] & ctrl_q[CTL_OPT_PROG];
  wire        bus_guard  = page_guarded(fl_addr, wrp_q, boot_open_q, restricted);
  wire        prog_ok    = fl_wr & sel_prog & !bus_guard;
  wire        oprog_ok   = fl_wr & sel_oprog & opt_wr_q & is_opt_page(fl_addr);
  wire        guard_pair = oprog_ok & (fl_addr == READ_GUARD_ADDR) & rdp_active_q
                         & (i_hwdata[7:0] == READ_GUARD_OPEN)
                         & (i_hwdata[23:16] == READ_GUARD_INV);
  wire        prog_bad   = fl_wr & ((sel_prog & !prog_ok) | (sel_oprog & !oprog_ok));
  wire        blank_miss = (i_fl_rdata != ERASED_WORD);
  wire        read_block = rdp_active_q & restricted & (fl_addr < MAIN_LIMIT);

  wire        op_end     = i_fl_ack & ((st_q == BUS_PROG) | (st_q == BUS_ERASE));
  wire        blank_set  = i_fl_ack & (st_q == BUS_BLANK) & blank_miss;
  wire        guard_set  = in_data & !bus_error & (start_bad | prog_bad);
  wire        busy_d     = (st_d == BUS_PRE) | (st_d == BUS_BLANK)
                         | (st_d == BUS_PROG) | (st_d == BUS_ERASE);
  wire        hready_d   = (st_d == BUS_IDLE) | (st_d == BUS_ERR2);
  wire        hresp_d    = (st_d == BUS_ERR1) | (st_d == BUS_ERR2);

  //--------------------------------------------------------------
  // Bus and operation sequencer
  //--------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    flash_d = flash_q;
    case (st_q)
      BUS_IDLE, BUS_ERR2: begin
        st_d = accept ? BUS_DATA : BUS_IDLE;
      end
      BUS_DATA: begin
        st_d = BUS_IDLE;
        flash_d.addr  = fl_addr;
        flash_d.wdata = i_hwdata;
        if (bus_error) begin
          st_d = BUS_ERR1;
        end else if (go_mass | guard_pair) begin
          st_d = guard_pair ? BUS_PRE : BUS_ERASE;
          flash_d.req  = 1'b1;
          flash_d.op   = OP_MASS_ERASE;
          flash_d.addr = '0;
        end else if (page_ok | opter_ok) begin
          st_d = BUS_ERASE;
          flash_d.req  = 1'b1;
          flash_d.op   = OP_PAGE_ERASE;
          flash_d.addr = {target_q[17:PAGE_LSB], {PAGE_LSB{1'b0}}};
        end else if (prog_ok | oprog_ok) begin
          st_d = BUS_BLANK;
          flash_d.req = 1'b1;
          flash_d.op  = OP_READ;
        end else if (fl_rd) begin
          st_d = BUS_READ;
          flash_d.req = 1'b1;
          flash_d.op  = OP_READ;
        end
      end
      BUS_PRE: begin
        if (i_fl_ack) begin
          st_d = BUS_BLANK;
          flash_d.op   = OP_READ;
          flash_d.addr = fl_addr;
        end
      end
      BUS_BLANK: begin
        if (i_fl_ack) begin
          st_d = blank_miss ? BUS_IDLE : BUS_PROG;
          flash_d.req = !blank_miss;
          flash_d.op  = OP_PROG;
        end
      end
      BUS_READ, BUS_PROG, BUS_ERASE: begin
        if (i_fl_ack) begin
          st_d = BUS_IDLE;
          flash_d.req = 1'b0;
        end
      end
      BUS_ERR1: begin
        st_d = BUS_ERR2;
      end
      default: begin
        st_d = BUS_IDLE;
        flash_d.req = 1'b0;
      end
    endcase
  end

  always_comb begin
    key_d = key_q;
    if (key_wr) begin
      case (key_q)
        KEY_WAIT_FIRST:  key_d = is_first ? KEY_WAIT_SECOND : KEY_DEAD;
        KEY_WAIT_SECOND: key_d = is_second ? KEY_OPEN : KEY_DEAD;
        default:         key_d = key_q;
      endcase
    end
    if (relock) begin
      key_d = KEY_WAIT_FIRST;
    end
  end

  //--------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------
  always_comb begin
    reg_view = 32'h0000_0000;
    case (ofs)
      OFS_CTRL: begin
        reg_view[CTL_SEL_W-1:0] = ctrl_q;
        reg_view[CTL_RELOCK]    = !ctl_open;
        reg_view[CTL_OPT_WR]    = opt_wr_q;
      end
      OFS_STATUS: begin
        reg_view[ST_BUSY]  = busy_q;
        reg_view[ST_BLANK] = blank_q;
        reg_view[ST_GUARD] = guard_q;
        reg_view[ST_DONE]  = done_q;
      end
      OFS_TARGET: reg_view = target_q;
      OFS_PROT: begin
        reg_view[PR_READ_GUARD] = rdp_active_q;
        reg_view[PR_BOOT_OPEN]  = boot_open_q;
        reg_view[PR_DEBUG]      = dbg_q;
        reg_view[PR_SRAM]       = sram_q;
      end
      default: reg_view = 32'h0000_0000;
    endcase
  end

  always_comb begin
    rdata_d = rdata_q;
    if (in_data) begin
      rdata_d = (!write_q & is_reg) ? reg_view : 32'h0000_0000;
    end else if ((st_q == BUS_READ) & i_fl_ack) begin
      rdata_d = read_block ? 32'h0000_0000 : i_fl_rdata;
    end
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q     <= BUS_IDLE;
      flash_q  <= '0;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      busy_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      flash_q  <= flash_d;
      hready_q <= hready_d;
      hresp_q  <= hresp_d;
      rdata_q  <= rdata_d;
      busy_q   <= busy_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_q  <= '0;
      write_q <= 1'b0;
      word_q  <= 1'b0;
    end else if (accept) begin
      addr_q  <= i_haddr[18:0];
      write_q <= i_hwrite;
      word_q  <= (i_hsize == 3'h2);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_q    <= KEY_WAIT_FIRST;
      ctrl_q   <= '0;
      target_q <= 32'h0000_0000;
    end else begin
      key_q <= key_d;
      if (relock) begin
        ctrl_q <= '0;
      end else if (ctl_take) begin
        ctrl_q <= i_hwdata[CTL_SEL_W-1:0];
      end
      if (tgt_wr) begin
        target_q <= i_hwdata;
      end
    end
  end

  // Secondary unlock pairs; both need the control register open
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_step_q <= 1'b0;
      boot_open_q <= 1'b0;
      opt_step_q  <= 1'b0;
      opt_wr_q    <= 1'b0;
    end else if (relock | !ctl_open) begin
      boot_step_q <= 1'b0;
      boot_open_q <= 1'b0;
      opt_step_q  <= 1'b0;
      opt_wr_q    <= 1'b0;
    end else begin
      if (boot_wr) begin
        boot_step_q <= is_first & !boot_step_q;
        boot_open_q <= boot_open_q | (boot_step_q & is_second);
      end
      if (optk_wr) begin
        opt_step_q <= is_first & !opt_step_q;
      end
      if (optk_wr & opt_step_q & is_second) begin
        opt_wr_q <= 1'b1;
      end else if (ctl_take & !i_hwdata[CTL_OPT_WR]) begin
        opt_wr_q <= 1'b0;
      end
    end
  end

  // Status flags: a set in the same cycle as its clear wins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      blank_q <= 1'b0;
      guard_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      blank_q <= (blank_q & !(stat_wr & i_hwdata[ST_BLANK])) | blank_set;
      guard_q <= (guard_q & !(stat_wr & i_hwdata[ST_GUARD])) | guard_set;
      done_q  <= (done_q & !(stat_wr & i_hwdata[ST_DONE])) | op_end;
    end
  end

  // Mode pins come from outside the clock domain
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dbg_meta_q  <= 1'b0;
      dbg_q       <= 1'b0;
      sram_meta_q <= 1'b0;
      sram_q      <= 1'b0;
    end else begin
      dbg_meta_q  <= i_debug_mode;
      dbg_q       <= dbg_meta_q;
      sram_meta_q <= i_sram_boot;
      sram_q      <= sram_meta_q;
    end
  end

  // Option bytes are caught once, on the first edge after reset release
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      loaded_q     <= 1'b0;
      rdp_active_q <= 1'b1;
      wrp_q        <= '0;
    end else if (!loaded_q) begin
      loaded_q     <= 1'b1;
      rdp_active_q <= (rg_eff[7:0] != READ_GUARD_OPEN);
      wrp_q        <= wrp_eff;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign o_hreadyout         = hready_q;
  assign o_hresp             = hresp_q;
  assign o_hrdata            = rdata_q;
  assign o_flash             = flash_q;
  assign o_irq_hold          = busy_q;
  assign o_read_guard_active = rdp_active_q;
endmodule // fcu_flash_ctl_unit

// ### fcu_flash_ctl_unit_properties.sv
// Port checker for the flash control unit.
// Assumes one clock domain; bound to every unit instance.
`timescale 1ns/10ps
module fcu_flash_ctl_unit_properties
  import fcu_pkg::*;
(
  // Clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_reset_n,
  // Bus and macro
  input wire logic                  i_fl_ack,
  input wire logic [31:0]           i_fl_rdata,
  input wire logic                  o_hreadyout,
  input wire logic                  o_hresp,
  input wire logic                  o_irq_hold,
  input fcu_pkg::fcu_flash_req_type o_flash
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire busy_op = o_flash.req && o_flash.op != OP_READ;
  wire prog_go = o_flash.req && o_flash.op == OP_PROG;
  err_two_a: assert property ($rose(o_hresp) |-> !o_hreadyout ##1 o_hresp && o_hreadyout)
    else $error("error response shape wrong");
  busy_stall_a: assert property (o_irq_hold |-> !o_hreadyout)
    else $error("bus released while busy");
  irq_hold_a: assert property (busy_op |-> o_irq_hold)
    else $error("interrupts not held during operation");
  req_hold_a: assert property (o_flash.req && !i_fl_ack |=> o_flash.req && $stable(o_flash.addr))
    else $error("flash request dropped before ack");
  mass_addr_a: assert property (o_flash.req && o_flash.op == OP_MASS_ERASE |-> o_flash.addr == 18'h0)
    else $error("mass erase address not zero");
  page_base_a: assert property (o_flash.req && o_flash.op == OP_PAGE_ERASE |-> o_flash.addr[8:0] == 9'h0)
    else $error("page erase address not page base");
  blank_first_a: assert property ($rose(prog_go) |-> $past(i_fl_ack) && $past(i_fl_rdata) == ERASED_WORD)
    else $error("program without blank word");
  done_release_a: assert property (prog_go && i_fl_ack |=> o_hreadyout && !o_irq_hold)
    else $error("bus not released after program");
endmodule // fcu_flash_ctl_unit_properties

bind fcu_flash_ctl_unit fcu_flash_ctl_unit_properties i_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_fl_ack(i_fl_ack), .i_fl_rdata(i_fl_rdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_irq_hold(o_irq_hold), .o_flash(o_flash));

// ### fcu_flash_ctl_unit_tb_top.sv
// Self-checking bench for the flash control unit over AHB-Lite.
// Assumes the unit is the only slave; a behavioural macro answers it.
`timescale 1ns/10ps
module fcu_flash_ctl_unit_tb_top;
  import fcu_pkg::*;
  localparam logic [31:0] UNL = {24'h000400, OFS_UNLOCK};
  localparam logic [31:0] BTU = {24'h000400, OFS_BOOT_UNLOCK};
  localparam logic [31:0] OPT = {24'h000400, OFS_OPT_UNLOCK};
  localparam logic [31:0] CTL = {24'h000400, OFS_CTRL};
  localparam logic [31:0] STA = {24'h000400, OFS_STATUS};
  localparam logic [31:0] TGT = {24'h000400, OFS_TARGET};
  localparam logic [31:0] K1  = UNLOCK_WORD_FIRST;
  localparam logic [31:0] K2  = UNLOCK_WORD_SECOND;
  logic              i_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  logic              hsel = 1'b0, hwrite = 1'b0, dbg = 1'b0, slow = 1'b0, sram = 1'b0;
  logic              hready, hresp, ack, rg_act, rsp_v;
  logic [1:0]        htrans = 2'b00;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rdata, rd_v;
  logic [31:0]       gw = 32'hFFFF_FFFF;
  fcu_flash_req_type flash;
  int                error_cnt = 0;
  int                n_checks = 0;
  always #20 i_clk = ~i_clk;
  // ----------------
  // Unit and macro
  // ----------------
  fcu_flash_ctl_unit i_fcu_flash_ctl_unit (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .o_flash(flash),
    .i_fl_ack(ack), .i_fl_rdata(rdata), .i_opt_read_guard_word(gw),
    .i_opt_write_guard_words({{7{32'h0000_FFFF}}, 32'h0004_FFFB}), .i_debug_mode(dbg),
    .i_sram_boot(sram), .o_irq_hold(), .o_read_guard_active(rg_act));
  fcu_flash_model i_fcu_flash_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_flash(flash),
    .i_slow(slow), .o_ack(ack), .o_rdata(rdata));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Entered just after a rising edge; leaves at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [31:0] a, d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rsp_v = 1'b0;
    do begin
      @(posedge i_clk);
      rsp_v |= hresp;
    end while (hready !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic w(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask
  task automatic r(input logic [31:0] a, exp, m = 32'hFFFF_FFFF);
    bus(1'b0, a, 32'h0);
    chk(exp, rd_v & m);
  endtask
  task automatic st(input logic [31:0] exp);
    r(STA, exp);
    w(STA, 32'h34);
  endtask
  task automatic err;
    chk(32'h1, {31'h0, rsp_v});
  endtask
  task automatic do_reset(input logic [31:0] g);
    gw        <= g;
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_unlock;
    w(CTL, 32'h01);
    r(CTL, 32'h40, 32'h7F);
    w(UNL, K1);
    w(UNL, K2);
    w(CTL, 32'h01);
    r(CTL, 32'h01, 32'h7F);
  endtask
  task automatic t_prog;
    w(32'h404, 32'h1234_5678);
    st(32'h20);
    r(32'h404, 32'h1234_5678);
    w(32'h404, 32'h0);
    st(32'h04);
    r(32'h404, 32'h1234_5678);
    w(32'h804, 32'h0);
    st(32'h10);
    w(32'h004, 32'h0);
    st(32'h10);
    w(BTU, K1);
    w(BTU, K2);
    w(32'h004, 32'hA5A5_0F0F);
    st(32'h20);
  endtask
  task automatic t_erase;
    w(TGT, 32'h400);
    w(CTL, 32'h22);
    st(32'h20);
    r(32'h404, ERASED_WORD);
    r(32'h004, 32'hA5A5_0F0F);
    w(TGT, 32'h800);
    w(CTL, 32'h22);
    st(32'h10);
  endtask
  task automatic t_debug;
    w(CTL, 32'h01);
    w(32'h604, 32'h0BAD_F00D);
    st(32'h20);
    dbg <= 1'b1;
    repeat (3) @(posedge i_clk);
    r(32'h604, 32'h0);
    w(32'h608, 32'h0);
    st(32'h10);
    w(CTL, 32'h24);
    st(32'h20);
    dbg <= 1'b0;
    sram <= 1'b1;
    repeat (3) @(posedge i_clk);
    r(32'h004, 32'h0);
    sram <= 1'b0;
    repeat (3) @(posedge i_clk);
    r(32'h004, ERASED_WORD);
  endtask
  task automatic t_opt;
    w(CTL, 32'h01);
    w(32'h404, 32'h1);
    st(32'h20);
    w(OPT, K1);
    w(OPT, K2);
    w(CTL, 32'h88);
    r(CTL, 32'h88, 32'hFF);
    w(32'h201F8, 32'h005A_00A5);
    r(32'h404, ERASED_WORD);
    r(32'h201F8, 32'h005A_00A5);
    w(CTL, 32'h08);
    r(CTL, 32'h08, 32'hFF);
  endtask
  task automatic t_keys;
    w(CTL, 32'h40);
    w(CTL, 32'h01);
    r(CTL, 32'h40, 32'h7F);
    w(UNL, K2);
    err;
    w(UNL, K1);
    err;
    w(UNL, K2);
    w(CTL, 32'h01);
    r(CTL, 32'h40, 32'h7F);
    r(32'h4_0040, 32'h0, 32'h0);
    err;
    chk(32'h1, {31'h0, rg_act});
    do_reset(32'h0000_00A5);
    chk(32'h1, {31'h0, rg_act});
    do_reset(32'hFF5A_00A5);
    chk(32'h0, {31'h0, rg_act});
    w(UNL, K1);
    w(UNL, K1);
    err;
  endtask
  initial begin
    do_reset(32'hFFFF_FFFF);
    t_unlock;
    t_prog;
    slow <= 1'b1;
    t_erase;
    t_debug;
    t_opt;
    t_keys;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    stop_test;
  end
endmodule // fcu_flash_ctl_unit_tb_top

// ### fcu_flash_model.sv
// Flash macro model: word store answering each request with one ack pulse.
// Assumes req is held until ack; i_slow stretches every answer.
`timescale 1ns/10ps
module fcu_flash_model
  import fcu_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // Request side
  input  fcu_pkg::fcu_flash_req_type i_flash,
  input  wire logic                  i_slow,
  output logic                       o_ack,
  output logic [31:0]                o_rdata
);
  logic [31:0] mem_q [int];
  int          wait_q;
  // Read data turns over every idle cycle so stale values are never taken
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0;
      wait_q  <= 0;
    end else if (o_ack || !i_flash.req || wait_q < (i_slow ? 3 : 0)) begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      wait_q  <= (i_flash.req && !o_ack) ? wait_q + 1 : 0;
    end else begin
      o_ack  <= 1'b1;
      wait_q <= 0;
      case (i_flash.op)
        OP_READ: o_rdata <= mem_q.exists(i_flash.addr) ? mem_q[i_flash.addr] : ERASED_WORD;
        OP_PROG: mem_q[i_flash.addr] = i_flash.wdata;
        OP_PAGE_ERASE: for (int k = 0; k < 512; k += 4) mem_q.delete(i_flash.addr + k);
        default: for (int k = 0; k < 32'h20000; k += 4) mem_q.delete(k);
      endcase
    end
  end
endmodule // fcu_flash_model

// ### fcu_pkg.sv
// Flash controller package: register map, field positions, keys, types.
// Assumes a 32-bit AHB-Lite host bus and a flash macro on the same clock.
//
// How it works
// - Control opens only after first then second unlock word at unlock_reg.
// - Every reset leaves the control register locked.
// - A wrong unlock word gives a bus error and locks until reset.
// - Pages 0 and 1 also need the pair at boot_pages_unlock_reg.
// - Writing the relock bit locks control and all unlocks again.
// - Page erase with start erases only the page in erase_target_reg.
// - The bus is stalled and busy set while an operation runs.
// - Interrupts are held off while busy.
// - Done flag sets when an erase or word program completes.
// - Erasing a guarded page does nothing and sets guard_violation_flag.
// - Mass erase clears the whole main block and no auxiliary block.
// - A word write to a main address with word_program_sel programs it.
// - A non-blank destination sets blank_check_fault and drops the write.
// - Erase or program of a write-guarded page sets guard_violation_flag.
// - Each write_guard_bits bit guards two pages, loaded at reset.
// - Debug or SRAM boot forbids page ops; pages 0-1 guarded; mass erase ok.
// - Read protection is off only when read_guard_byte is 0xA5.
// - Protected main flash reads as zero to debug or SRAM-boot code.
// - Writing 0x5A/0xA5 guard pair while read protection is active mass erases main flash first.
// - An erased read_guard_byte reads 0xFF and keeps protection.
// - Option word with bad inverse half is taken as all ones.
// - Option writes need main pair then option pair; bit can clear.
package fcu_pkg;
  localparam logic [31:0] UNLOCK_WORD_FIRST  = 32'h4567_0123;
  localparam logic [31:0] UNLOCK_WORD_SECOND = 32'hCDEF_89AB;
  localparam logic [7:0]  READ_GUARD_OPEN    = 8'hA5;
  localparam logic [7:0]  READ_GUARD_INV     = 8'h5A;
  localparam logic [31:0] ERASED_WORD        = 32'hFFFF_FFFF;
  localparam logic [31:0] OPT_DEFAULT        = 32'hFFFF_FFFF;
  // Address map: bit 18 selects registers, else flash byte address
  localparam int          REG_SEL_BIT        = 18;
  localparam logic [17:0] MAIN_LIMIT         = 18'h2_0000;
  localparam logic [17:0] FLASH_TOP          = 18'h2_07FF;
  localparam logic [17:0] NVR1_BASE          = 18'h2_0000;
  localparam logic [17:0] NVR3_BASE          = 18'h2_0400;
  localparam logic [17:0] READ_GUARD_ADDR    = 18'h2_01F8;
  localparam int          PAGE_LSB           = 9;
  localparam int          PAGE_MSB           = 16;
  localparam logic [7:0]  BOOT_PAGES         = 8'h02;
  localparam int          WRP_WORDS          = 8;
  localparam int          WRP_BITS           = 16;
  // Register offsets
  localparam logic [7:0]  OFS_UNLOCK         = 8'h00;
  localparam logic [7:0]  OFS_BOOT_UNLOCK    = 8'h04;
  localparam logic [7:0]  OFS_OPT_UNLOCK     = 8'h08;
  localparam logic [7:0]  OFS_CTRL           = 8'h0C;
  localparam logic [7:0]  OFS_STATUS         = 8'h10;
  localparam logic [7:0]  OFS_TARGET         = 8'h14;
  localparam logic [7:0]  OFS_PROT           = 8'h18;
  // flash_control_reg fields
  localparam int          CTL_PROG           = 0;
  localparam int          CTL_PAGE_ER        = 1;
  localparam int          CTL_MASS_ER        = 2;
  localparam int          CTL_OPT_PROG       = 3;
  localparam int          CTL_OPT_ER         = 4;
  localparam int          CTL_START          = 5;
  localparam int          CTL_RELOCK         = 6;
  localparam int          CTL_OPT_WR         = 7;
  localparam int          CTL_SEL_W          = 5;
  // flash_status_reg fields
  localparam int          ST_BUSY            = 0;
  localparam int          ST_BLANK           = 2;
  localparam int          ST_GUARD           = 4;
  localparam int          ST_DONE            = 5;
  // Protection view fields
  localparam int          PR_READ_GUARD      = 0;
  localparam int          PR_BOOT_OPEN       = 1;
  localparam int          PR_DEBUG           = 2;
  localparam int          PR_SRAM            = 3;

  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_PAGE_ERASE, OP_MASS_ERASE} fcu_op_type;

  typedef struct packed {
    logic        req;
    fcu_op_type  op;
    logic [17:0] addr;
    logic [31:0] wdata;
  } fcu_flash_req_type;

  typedef enum logic [1:0] {KEY_WAIT_FIRST, KEY_WAIT_SECOND, KEY_OPEN, KEY_DEAD} fcu_key_type;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_DATA, BUS_READ, BUS_PRE, BUS_BLANK, BUS_PROG, BUS_ERASE, BUS_ERR1, BUS_ERR2
  } fcu_bus_type;
endpackage
